// ==== pkg/ppsd_defs.svh ====
// offsets, field positions, reset values and counts of the swallow divider
`ifndef PPSD_DEFS_SVH
`define PPSD_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PPSD_OFF_SET      12'h000
`define PPSD_OFF_CTRL     12'h004
`define PPSD_OFF_STAT     12'h008

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PPSD_SET_RST      18'h0_0000
`define PPSD_CTRL_RST     3'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PPSD_CTRL_SIMPLE  0
`define PPSD_CTRL_PSZ_LO  1
`define PPSD_CTRL_PSZ_HI  2
`define PPSD_SET_BCD      17
`define PPSD_STAT_MODSEL  0
`define PPSD_STAT_PULSE   1
`define PPSD_STAT_RUN     2
`define PPSD_STAT_ZERR    3
`define PPSD_STAT_RERR    4
`define PPSD_STAT_CNT_LO  16

// ----------------------------------------------------------------------
// counts and limits
// ----------------------------------------------------------------------
`define PPSD_PULSE_W      3'h4
`define PPSD_MIN_RATIO    16'h0005
`define PPSD_BCD_MAX      4'h9
`define PPSD_ZMASK_64     18'h0_0040
`define PPSD_ZMASK_32     18'h0_0060
`define PPSD_ZMASK_16     18'h0_0070

`endif

// ==== pkg/ppsd_pkg.sv ====
// types shared by the swallow divider
`default_nettype none

package ppsd_pkg;

	// ------------------------------------------------------------------
	// prescaler size and control
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PPSD_P128 = 2'h0,
		PPSD_P64  = 2'h1,
		PPSD_P32  = 2'h2,
		PPSD_P16  = 2'h3
	} ppsd_psize_t;

	typedef struct packed {
		ppsd_psize_t psize;
		logic        simple;
	} ppsd_ctrl_t;

	// ------------------------------------------------------------------
	// decoded ratio and sequencer state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        ok;
		logic [15:0] n;
		logic [6:0]  a;
	} ppsd_ratio_t;

	typedef enum logic [1:0] {
		PPSD_ST_IDLE = 2'b01,
		PPSD_ST_RUN  = 2'b10
	} ppsd_state_t;

endpackage

`default_nettype wire

// ==== rtl/ppsd_divider.sv ====
// pin programmed swallow divider with apb setting registers
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ppsd_defs.svh"

module ppsd_divider #(
	parameter int SWAL_W = 7,
	parameter int MAIN_W = 11
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// prescaler link
	input  wire logic        prescaled_in,
	output logic             modulus_select_out,
	output logic             divided_pulse_out
);
	import ppsd_pkg::*;

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	// the eighteen setting weights are fixed by the pin layout
	if (SWAL_W != 7 || MAIN_W != 11) begin : g_bad_width
		$error("ppsd_divider: counter widths must be 7 and 11");
	end

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	function automatic logic [17:0] zmask(input ppsd_psize_t p);
		unique case (p)
			PPSD_P64: zmask = `PPSD_ZMASK_64;
			PPSD_P32: zmask = `PPSD_ZMASK_32;
			PPSD_P16: zmask = `PPSD_ZMASK_16;
			PPSD_P128: zmask = 18'h0_0000;
		endcase
	endfunction

	function automatic logic digit_ok(input logic [3:0] d);
		digit_ok = (d <= `PPSD_BCD_MAX);
	endfunction

	function automatic ppsd_ratio_t decode(input logic [17:0] s, input ppsd_ctrl_t c);
		ppsd_ratio_t r;
		r = '0;
		if (!c.simple) begin
			r.a = s[6:0];
			r.n = {5'h00, s[17:7]};
			r.ok = (r.n > {9'h000, r.a});
		end else if (s[`PPSD_SET_BCD]) begin
			r.n = 16'(s[3:0]) + 16'(s[7:4]) * 16'h000a
				+ 16'(s[11:8]) * 16'h0064
				+ 16'(s[15:12]) * 16'h03e8;
			r.ok = digit_ok(s[3:0]) && digit_ok(s[7:4]) && digit_ok(s[11:8])
				&& (r.n >= `PPSD_MIN_RATIO);
		end else begin
			r.n = s[15:0];
			r.ok = (r.n >= `PPSD_MIN_RATIO);
		end
		decode = r;
	endfunction

	// ------------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------------
	logic [17:0] set_r;
	ppsd_ctrl_t  ctrl_r;
	ppsd_state_t st_r;
	ppsd_state_t st_nxt;
	logic [15:0] n_r;
	logic [15:0] n_nxt;
	logic [6:0]  a_r;
	logic [6:0]  a_nxt;
	logic        simple_r;
	logic        simple_nxt;
	logic [15:0] ratio_r;
	logic [2:0]  pw_r;
	logic [2:0]  pw_nxt;
	logic        in_q_r;
	logic        in_edge;
	logic        load_c;
	logic        modsel_r;
	logic        pulse_r;
	logic        zerr_r;
	logic        rerr_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	ppsd_ratio_t dec;

	assign dec = decode(set_r, ctrl_r);

	// ------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------
	// zero wait states: read data is captured in the setup cycle
	logic setup_c;
	logic wr_c;
	logic hit_c;

	assign setup_c = psel && !penable;
	assign wr_c    = psel && penable && pwrite;
	assign hit_c   = (paddr == `PPSD_OFF_SET) || (paddr == `PPSD_OFF_CTRL)
		|| (paddr == `PPSD_OFF_STAT);
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_c) begin
			pslverr_r <= !hit_c || (pwrite && paddr == `PPSD_OFF_STAT);
			prdata_r  <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					`PPSD_OFF_SET:  prdata_r <= {14'h0000, set_r};
					`PPSD_OFF_CTRL: prdata_r <= {29'h0000_0000, ctrl_r};
					`PPSD_OFF_STAT: prdata_r <= {n_r, 11'h000, rerr_r, zerr_r,
						st_r == PPSD_ST_RUN, pulse_r, modsel_r};
					default:        prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_r  <= `PPSD_SET_RST;
			ctrl_r <= ppsd_ctrl_t'(`PPSD_CTRL_RST);
		end else if (wr_c && paddr == `PPSD_OFF_SET) begin
			set_r <= pwdata[17:0];
		end else if (wr_c && paddr == `PPSD_OFF_CTRL) begin
			ctrl_r <= ppsd_ctrl_t'(pwdata[`PPSD_CTRL_PSZ_HI:`PPSD_CTRL_SIMPLE]);
		end
	end

	// ------------------------------------------------------------------
	// input edge
	// ------------------------------------------------------------------
	// prescaler output is synchronous; one rising edge is one period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_q_r <= 1'b0;
		end else begin
			in_q_r <= prescaled_in;
		end
	end

	assign in_edge = prescaled_in && !in_q_r;
	assign load_c  = in_edge && dec.ok && (st_r == PPSD_ST_IDLE || n_r == 16'h0000);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		n_nxt      = n_r;
		a_nxt      = a_r;
		simple_nxt = simple_r;
		pw_nxt     = pw_r;
		if (load_c) begin
			st_nxt     = PPSD_ST_RUN;
			n_nxt      = dec.n - 16'h0001;
			a_nxt      = dec.a;
			simple_nxt = ctrl_r.simple;
			pw_nxt     = `PPSD_PULSE_W;
		end else if (in_edge) begin
			if (pw_r != 3'h0) begin
				pw_nxt = pw_r - 3'h1;
			end
			unique case (st_r)
				PPSD_ST_IDLE: begin
					st_nxt = PPSD_ST_IDLE;
				end
				PPSD_ST_RUN: begin
					if (n_r == 16'h0000) begin
						// a bad setting halts at the boundary
						st_nxt = PPSD_ST_IDLE;
					end else begin
						n_nxt = n_r - 16'h0001;
						if (a_r != 7'h00) begin
							a_nxt = a_r - 7'h01;
						end
					end
				end
				default: st_nxt = PPSD_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r     <= PPSD_ST_IDLE;
			n_r      <= 16'h0000;
			a_r      <= 7'h00;
			simple_r <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			n_r      <= n_nxt;
			a_r      <= a_nxt;
			simple_r <= simple_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_r <= 16'h0000;
		end else if (load_c) begin
			ratio_r <= dec.n;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// select stays at P when idle or simple so a prescaler never sees P+1 alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modsel_r <= 1'b1;
		end else begin
			modsel_r <= (st_nxt != PPSD_ST_RUN) || simple_nxt || (a_nxt == 7'h00);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_r    <= 3'h0;
			pulse_r <= 1'b0;
		end else begin
			pw_r    <= pw_nxt;
			pulse_r <= (pw_nxt != 3'h0);
		end
	end

	assign modulus_select_out = modsel_r;
	assign divided_pulse_out  = pulse_r;

	// ------------------------------------------------------------------
	// setting checks
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zerr_r <= 1'b0;
			rerr_r <= 1'b0;
		end else begin
			zerr_r <= !ctrl_r.simple && ((set_r & zmask(ctrl_r.psize)) != 18'h0_0000);
			rerr_r <= !dec.ok;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	logic [2:0]  pw_seen_r;
	logic [15:0] per_cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_seen_r <= 3'h0;
			per_cnt_r <= 16'h0000;
		end else begin
			pw_seen_r <= !pulse_r ? 3'h0 : pw_seen_r + {2'h0, in_edge};
			per_cnt_r <= load_c ? 16'h0001 : per_cnt_r + {15'h0000, in_edge};
		end
	end

	simple_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == PPSD_ST_RUN && simple_r) |-> modulus_select_out)
		else $error("select not at P in simple mode");

	swallow_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == PPSD_ST_RUN && !simple_r) |-> (modulus_select_out == (a_r == 7'h00)))
		else $error("select does not follow swallow count");

	swal_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == PPSD_ST_RUN && !simple_r) |-> ({9'h000, a_r} <= n_r))
		else $error("swallow count outran main count");

	swal_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(load_c && !ctrl_r.simple) |=> (a_r == $past(set_r[6:0]))
		&& (n_r == {5'h00, $past(set_r[17:7])} - 16'h0001))
		else $error("swallow counters loaded wrong");

	pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(divided_pulse_out) |-> (pw_seen_r == 3'h4))
		else $error("pulse not four input cycles");

	period_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == PPSD_ST_RUN && in_edge && n_r == 16'h0000) |-> (per_cnt_r == ratio_r))
		else $error("period differs from ratio");

	reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_edge && st_r == PPSD_ST_RUN && n_r == 16'h0000 && dec.ok)
		|=> (st_r == PPSD_ST_RUN) && (n_r == $past(dec.n) - 16'h0001) ##1 divided_pulse_out)
		else $error("no reload at boundary");

	bcd_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_edge && st_r == PPSD_ST_IDLE && ctrl_r.simple && set_r[`PPSD_SET_BCD]
		&& set_r[3:0] > `PPSD_BCD_MAX) |=> (st_r == PPSD_ST_IDLE))
		else $error("bad bcd digit started counting");

	bin_min_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_edge && st_r == PPSD_ST_IDLE && ctrl_r.simple && !set_r[`PPSD_SET_BCD]
		&& set_r[15:0] < `PPSD_MIN_RATIO) |=> (st_r == PPSD_ST_IDLE))
		else $error("binary ratio below five started");

	zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_r.simple && ctrl_r.psize == PPSD_P32 && set_r[5]) |=> zerr_r)
		else $error("held-zero bit not flagged");

	swal_pulse_c: cover property (@(posedge pclk) disable iff (!presetn)
		!simple_r && $rose(divided_pulse_out));
	bin_pulse_c: cover property (@(posedge pclk) disable iff (!presetn)
		simple_r && !set_r[`PPSD_SET_BCD] && $rose(divided_pulse_out));
	bcd_pulse_c: cover property (@(posedge pclk) disable iff (!presetn)
		simple_r && set_r[`PPSD_SET_BCD] && $rose(divided_pulse_out));
	halt_c: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(st_r == PPSD_ST_RUN));

endmodule

`default_nettype wire

// ==== verif/ppsd_prescaler.sv ====
// two-modulus prescaler model feeding the divider input
`timescale 1ns/100ps
`default_nettype none

module ppsd_prescaler #(
	parameter int P = 4
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// link
	input  wire logic modulus_select_out,
	output logic      prescaled_in
);
	logic [7:0] cnt_r;

	// ------------------------------------------------------------------
	// modulus sampled only at reload, as a real prescaler commits per period
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= 8'(P - 1);
		else if (cnt_r == 8'h00)
			cnt_r <= modulus_select_out ? 8'(P - 1) : 8'(P);
		else
			cnt_r <= cnt_r - 8'h01;
	end

	// two cycles high, so edges are always at least two cycles apart
	assign prescaled_in = (cnt_r < 8'h02);
endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the swallow divider
`timescale 1ns/100ps
`default_nettype none
`include "ppsd_defs.svh"

module tb_top;
	import ppsd_pkg::*;
	localparam int PS = 4;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        msel;
	logic        pulse;
	logic [31:0] rd;
	int          errors;
	int          n_tests;
	int          cyc;
	int          per;
	int          hi;
	int          lo;

	ppsd_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prescaled_in(pin), .modulus_select_out(msel),
		.divided_pulse_out(pulse));
	ppsd_prescaler #(.P(PS)) u_pre (.pclk(pclk), .presetn(presetn),
		.modulus_select_out(msel), .prescaled_in(pin));

	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic cfg(input logic [2:0] c, input logic [17:0] s);
		apb(1'b1, `PPSD_OFF_SET, {14'h0, s}, 1'b0);
		apb(1'b1, `PPSD_OFF_CTRL, {29'h0, c}, 1'b0);
	endtask

	// one full output period after two settling pulses
	task automatic meas();
		logic pv;
		per = 0;
		hi = 0;
		lo = 0;
		repeat (2) @(posedge pulse);
		@(negedge pclk);
		do begin
			per++;
			hi += int'(pulse);
			lo += int'(!msel);
			pv = pulse;
			@(negedge pclk);
		end while (!(pulse && !pv));
		@(posedge pclk);
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		chk({31'h0, msel}, 32'h1);
		apb(1'b0, `PPSD_OFF_SET, 32'h0, 1'b0);
		chk(rd, 32'h0);
		apb(1'b0, `PPSD_OFF_CTRL, 32'h0, 1'b0);
		chk(rd, 32'h0);
		apb(1'b0, `PPSD_OFF_STAT, 32'h0, 1'b0);
		chk(rd, 32'h0000_0011);
		apb(1'b0, 12'h010, 32'h0, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, `PPSD_OFF_STAT, 32'h0000_001F, 1'b1);
		$display("test regs done");
	endtask

	// swallow: N periods per pulse, select low for the first A of them
	task automatic t_swallow();
		int tn[2] = '{5, 7};
		int ta[2] = '{2, 6};
		for (int i = 0; i < 2; i++) begin
			cfg(3'h0, 18'((tn[i] << 7) | ta[i]));
			meas();
			chk(32'(per), 32'(tn[i] * PS + ta[i]));
			chk(32'(lo), 32'(ta[i] * (PS + 1)));
			chk(32'(hi), 32'(4 * PS + ((ta[i] < 4) ? ta[i] : 4)));
		end
		$display("test swallow done");
	endtask

	// bit 16 set to show it is ignored; ratio 5 is the lowest legal value
	task automatic t_binary();
		cfg(3'h1, 18'h1_0005);
		meas();
		chk(32'(per), 32'(5 * PS));
		chk(32'(hi), 32'(4 * PS));
		chk(32'(lo), 32'h0);
		$display("test binary done");
	endtask

	task automatic t_invalid();
		logic [2:0]  c[3] = '{3'h0, 3'h1, 3'h1};
		logic [17:0] s[3] = '{18'h0_0103, 18'h0_0004, 18'h2_000A};
		int          n;
		for (int i = 0; i < 3; i++) begin
			cfg(c[i], s[i]);
			repeat (60) @(posedge pclk);
			n = 0;
			repeat (200) begin
				@(posedge pclk);
				n += int'(pulse);
			end
			chk(32'(n), 32'h0);
			apb(1'b0, `PPSD_OFF_STAT, 32'h0, 1'b0);
			chk({30'h0, rd[4], rd[0]}, 32'h3);
		end
		$display("test invalid done");
	endtask

	// each mask probed just inside and just outside its held-zero bits
	task automatic t_zero();
		logic [2:0]  c[7] = '{3'h0, 3'h2, 3'h2, 3'h4, 3'h4, 3'h6, 3'h6};
		logic [17:0] s[7] = '{18'h3_FFF0, 18'h3_FFC0, 18'h3_FFB0, 18'h3_FFA0,
			18'h3_FF90, 18'h3_FF90, 18'h3_FF88};
		logic        e[7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 7; i++) begin
			cfg(c[i], s[i]);
			apb(1'b0, `PPSD_OFF_STAT, 32'h0, 1'b0);
			chk({31'h0, rd[3]}, {31'h0, e[i]});
		end
		$display("test zero done");
	endtask

	// every bcd digit weighted, thousands digit nonzero
	task automatic t_bcd();
		cfg(3'h1, 18'h2_1234);
		meas();
		chk(32'(per), 32'(1234 * PS));
		chk(32'(hi), 32'(4 * PS));
		apb(1'b0, `PPSD_OFF_STAT, 32'h0, 1'b0);
		chk({29'h0, rd[4], rd[2], rd[0]}, 32'h3);
		$display("test bcd done");
	endtask

	// ------------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------------
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_swallow();
		t_binary();
		t_invalid();
		t_zero();
		t_bcd();
		final_report();
	end
endmodule

`default_nettype wire
